//--- tcd_terminal_command_decoder.v
// Operation
// - Four switches pick one of sixteen presets
// - Preset 100% equals maximum output frequency
// - Preset may feed PID or V/F voltage
// - Two ramp terminals pick time pair 1..4
// - Digital filter time 0 to 1 s
// - Command mode select, two/three wire, default 0
// - Two-wire 1: forward, reverse, else stop
// - Two-wire 2: run enable plus direction input
// - Three-wire 1: buttons start forward or reverse
// - Three-wire 1: enable low stops, last action wins
// - Three-wire 2: run button, maintained direction input
// - Up/down rate 0.001 to 65.535 Hz/s
// - Coarse resolution: rate has one fewer decimal
// - Analog mapped linearly between two points
// - Analog above maximum point taken as maximum
// - Analog below minimum point taken as minimum
// - Current mode: one mA counts half volt
// - Analog low-pass filter 0 to 10 s
// - Below minimum: minimum setting or zero
// - Per-terminal polarity inversion
`timescale 1ns/100ps
`default_nettype none
`include "tcd_defs.vh"

module tcd_terminal_command_decoder #(
  parameter TICK_CYCLES = `TCD_TICK_US * `TCD_CLK_MHZ
) (
  // Clock and reset
  input  wire                          clock,
  input  wire                          nrst,
  // Digital input terminals and their setup
  input  wire [`TCD_NUM_IN-1:0]        terminal_raw,
  input  wire [`TCD_NUM_IN-1:0]        input_polarity_select,
  input  wire [9:0]                    input_debounce_time,
  input  wire [1:0]                    terminal_command_mode_select,
  // Presets and frequency setup
  input  wire [16*`TCD_REF_W-1:0]      preset_reference_table,
  input  wire [15:0]                   maximum_frequency_setting,
  input  wire [1:0]                    reference_destination,
  input  wire [15:0]                   updown_ramp_rate,
  input  wire [1:0]                    frequency_resolution_select,
  // Analog input and its curve
  input  wire [11:0]                   analog_input_one,
  input  wire                          analog_current_mode,
  input  wire [9:0]                    analog_min_input_point,
  input  wire [9:0]                    analog_max_input_point,
  input  wire signed [10:0]            analog_min_setting,
  input  wire signed [10:0]            analog_max_setting,
  input  wire [9:0]                    analog_filter_time,
  input  wire                          below_minimum_handling,
  // Commands out
  output reg                           run_command,
  output reg                           reverse_command,
  output reg  [1:0]                    ramp_pair_select,
  output reg  [3:0]                    preset_index,
  output reg  signed [16:0]            speed_reference,
  output reg  signed [`TCD_REF_W-1:0]  pid_setpoint,
  output reg  signed [`TCD_REF_W-1:0]  vf_voltage_setting,
  output reg  [31:0]                   updown_frequency,
  output reg  signed [10:0]            analog_setting,
  output reg  [`TCD_NUM_IN-1:0]        terminal_state
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function signed [31:0] tcd_clamp;
    input signed [31:0] v;
    input signed [31:0] lo;
    input signed [31:0] hi;
    begin
      if (v < lo)
        tcd_clamp = lo;
      else if (v > hi)
        tcd_clamp = hi;
      else
        tcd_clamp = v;
    end
  endfunction

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  reg  [17:0] tick_cnt;
  reg         tick;

  always @(posedge clock) begin
    if (!nrst) begin
      tick_cnt <= 18'h00000;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES - 1) begin
      tick_cnt <= 18'h00000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 18'h00001;
      tick     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Polarity and debounce
  // ----------------------------------------------------------------
  reg  [9:0]             deb_cnt [0:`TCD_NUM_IN-1];
  reg  [9:0]             deb_limit;
  wire [`TCD_NUM_IN-1:0] sample;
  integer                i;

  assign sample = terminal_raw ^ input_polarity_select;

  always @* begin
    if (input_debounce_time > `TCD_DEB_MAX_MS)
      deb_limit = `TCD_DEB_MAX_MS;
    else
      deb_limit = input_debounce_time;
  end

  always @(posedge clock) begin
    if (!nrst) begin
      terminal_state <= {`TCD_NUM_IN{1'b0}};
      for (i = 0; i < `TCD_NUM_IN; i = i + 1)
        deb_cnt[i] <= 10'h000;
    end else begin
      for (i = 0; i < `TCD_NUM_IN; i = i + 1) begin
        if (sample[i] == terminal_state[i]) begin
          deb_cnt[i] <= 10'h000;
        end else if (deb_limit == 10'h000) begin
          terminal_state[i] <= sample[i];
        end else if (tick) begin
          if (deb_cnt[i] + 10'h001 >= deb_limit) begin
            terminal_state[i] <= sample[i];
            deb_cnt[i]        <= 10'h000;
          end else begin
            deb_cnt[i] <= deb_cnt[i] + 10'h001;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Run and direction
  // ----------------------------------------------------------------
  wire t_fwd = terminal_state[`TCD_IN_FWD];
  wire t_dir = terminal_state[`TCD_IN_DIR];
  wire t_ena = terminal_state[`TCD_IN_ENA];
  reg  prev_fwd;
  reg  prev_dir;
  reg  latch_run;
  reg  latch_rev;
  reg  next_run;
  reg  next_rev;
  wire three_wire = terminal_command_mode_select[1];
  wire press_fwd  = t_fwd & ~prev_fwd;
  wire press_rev  = t_dir & ~prev_dir;

  always @(posedge clock) begin
    if (!nrst) begin
      prev_fwd  <= 1'b0;
      prev_dir  <= 1'b0;
      latch_run <= 1'b0;
      latch_rev <= 1'b0;
    end else begin
      prev_fwd <= t_fwd;
      prev_dir <= t_dir;
      if (!three_wire || !t_ena) begin
        latch_run <= 1'b0;
      end else if (terminal_command_mode_select == `TCD_MODE_3W1) begin
        // momentary buttons start, last press wins
        if (press_fwd) begin
          latch_run <= 1'b1;
          latch_rev <= 1'b0;
        end else if (press_rev) begin
          latch_run <= 1'b1;
          latch_rev <= 1'b1;
        end
      end else if (press_fwd) begin
        latch_run <= 1'b1;
      end
    end
  end

  always @* begin
    next_run = 1'b0;
    next_rev = 1'b0;
    case (terminal_command_mode_select)
      `TCD_MODE_2W1: begin
        // exactly one of forward and reverse
        next_run = t_fwd ^ t_dir;
        next_rev = t_dir & ~t_fwd;
      end
      `TCD_MODE_2W2: begin
        next_run = t_fwd;
        next_rev = t_fwd & t_dir;
      end
      `TCD_MODE_3W1: begin
        next_run = latch_run & t_ena;
        next_rev = latch_rev;
      end
      `TCD_MODE_3W2: begin
        next_run = latch_run & t_ena;
        next_rev = t_dir;
      end
      default: begin
        next_run = 1'b0;
        next_rev = 1'b0;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!nrst) begin
      run_command      <= 1'b0;
      reverse_command  <= 1'b0;
      ramp_pair_select <= 2'h0;
      preset_index     <= 4'h0;
    end else begin
      run_command      <= next_run;
      reverse_command  <= next_rev;
      ramp_pair_select <= terminal_state[`TCD_IN_RAMP_LO +: 2];
      preset_index     <= terminal_state[`TCD_IN_REF_LO +: 4];
    end
  end

  // ----------------------------------------------------------------
  // Preset reference scaling
  // ----------------------------------------------------------------
  wire signed [`TCD_REF_W-1:0] sel_ref =
    preset_reference_table[preset_index*`TCD_REF_W +: `TCD_REF_W];
  wire signed [33:0] ref_prod =
    sel_ref * $signed({1'b0, maximum_frequency_setting});
  wire signed [33:0] ref_freq = ref_prod / `TCD_PCT_FULL;

  always @(posedge clock) begin
    if (!nrst) begin
      speed_reference    <= 17'h00000;
      pid_setpoint       <= 16'h0000;
      vf_voltage_setting <= 16'h0000;
    end else begin
      speed_reference <= (reference_destination == `TCD_DEST_SPEED) ?
                         ref_freq[16:0] : 17'h00000;
      pid_setpoint <= (reference_destination == `TCD_DEST_PID) ?
                      sel_ref : 16'h0000;
      vf_voltage_setting <= (reference_destination == `TCD_DEST_VF) ?
                            sel_ref : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Up/down frequency ramp
  // ----------------------------------------------------------------
  reg  signed [31:0] ud_next;
  reg  signed [31:0] ud_step;
  wire signed [31:0] ud_top =
    $signed({16'h0000, maximum_frequency_setting}) * `TCD_UD_SCALE;

  always @* begin
    if (frequency_resolution_select == `TCD_RES_COARSE)
      ud_step = $signed({16'h0000, updown_ramp_rate}) * `TCD_UD_COARSE;
    else
      // rate in mHz/s, added each ms as uHz
      ud_step = $signed({16'h0000, updown_ramp_rate});
    ud_next = $signed(updown_frequency);
    if (terminal_state[`TCD_IN_UP] && !terminal_state[`TCD_IN_DOWN])
      ud_next = ud_next + ud_step;
    else if (terminal_state[`TCD_IN_DOWN] && !terminal_state[`TCD_IN_UP])
      ud_next = ud_next - ud_step;
    ud_next = tcd_clamp(ud_next, 32'sh00000000, ud_top);
  end

  always @(posedge clock) begin
    if (!nrst)
      updown_frequency <= 32'h00000000;
    else if (tick)
      updown_frequency <= ud_next;
  end

  // ----------------------------------------------------------------
  // Analog input filter and curve
  // ----------------------------------------------------------------
  reg  signed [23:0] ai_filt;
  reg  signed [23:0] ai_in;
  reg  signed [23:0] ai_step;
  reg  signed [15:0] ai_div;
  reg  signed [31:0] ai_v;
  reg  signed [31:0] ai_num;
  reg  signed [31:0] ai_den;
  reg  signed [31:0] ai_set;
  reg  [9:0]         aflt;

  always @* begin
    // current mode: half a volt per mA
    if (analog_current_mode)
      ai_in = $signed({12'h000, analog_input_one >> 1}) <<< `TCD_AI_FRAC;
    else
      ai_in = $signed({12'h000, analog_input_one}) <<< `TCD_AI_FRAC;
    // filter time bounded at 10 s
    if (analog_filter_time > `TCD_AFLT_MAX)
      aflt = `TCD_AFLT_MAX;
    else
      aflt = analog_filter_time;
    ai_div  = $signed({6'h00, aflt}) * `TCD_AFLT_MS_PER;
    ai_step = (ai_div == 16'sh0000) ? (ai_in - ai_filt) :
              (ai_in - ai_filt) / ai_div;
  end

  always @(posedge clock) begin
    if (!nrst)
      ai_filt <= 24'sh000000;
    else if (aflt == 10'h000)
      ai_filt <= ai_in;
    else if (tick)
      ai_filt <= ai_filt + ai_step;
  end

  always @* begin
    ai_v = $signed({8'h00, ai_filt}) >>> `TCD_AI_FRAC;
    ai_v = tcd_clamp(ai_v,
                     $signed({22'h000000, analog_min_input_point}),
                     $signed({22'h000000, analog_max_input_point}));
    ai_num = (ai_v - $signed({22'h000000, analog_min_input_point})) *
             (analog_max_setting - analog_min_setting);
    ai_den = $signed({22'h000000, analog_max_input_point}) -
             $signed({22'h000000, analog_min_input_point});
    if (ai_den <= 32'sh00000000)
      ai_set = analog_min_setting;
    else
      ai_set = analog_min_setting + ai_num / ai_den;
    if (below_minimum_handling && ($signed({8'h00, ai_filt}) >>>
        `TCD_AI_FRAC) < $signed({22'h000000, analog_min_input_point}))
      ai_set = 32'sh00000000;
    ai_set = tcd_clamp(ai_set, -`TCD_PCT_FULL, `TCD_PCT_FULL);
  end

  always @(posedge clock) begin
    if (!nrst)
      analog_setting <= 11'h000;
    else
      analog_setting <= ai_set[10:0];
  end

endmodule

`default_nettype wire

//--- tcd_defs.vh
`ifndef TCD_DEFS_VH
`define TCD_DEFS_VH

// ----------------------------------------------------------------
// Terminal positions within the input word
// ----------------------------------------------------------------
`define TCD_NUM_IN       11
`define TCD_IN_W         4
`define TCD_IN_FWD       0
`define TCD_IN_DIR       1
`define TCD_IN_ENA       2
`define TCD_IN_REF_LO    3
`define TCD_IN_RAMP_LO   7
`define TCD_IN_UP        9
`define TCD_IN_DOWN      10

// ----------------------------------------------------------------
// Command modes and destinations
// ----------------------------------------------------------------
`define TCD_MODE_2W1     2'h0
`define TCD_MODE_2W2     2'h1
`define TCD_MODE_3W1     2'h2
`define TCD_MODE_3W2     2'h3
`define TCD_DEST_SPEED   2'h0
`define TCD_DEST_PID     2'h1
`define TCD_DEST_VF      2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TCD_CLK_MHZ      200
`define TCD_TICK_US      1000
`define TCD_DEB_DEF_MS   10
`define TCD_DEB_MAX_MS   10'h3E8
`define TCD_AFLT_MS_PER  16'h000A
`define TCD_AFLT_DEF     10'h00A
`define TCD_AFLT_MAX     10'h3E8

// ----------------------------------------------------------------
// Scaling
// ----------------------------------------------------------------
`define TCD_PCT_FULL     1000
`define TCD_RES_COARSE   2'h1
`define TCD_UD_COARSE    10
`define TCD_UD_SCALE     10000
`define TCD_AI_MAX_V     12'h3E8
`define TCD_AI_FRAC      8
`define TCD_REF_W        16

`endif

//--- tcd_switch_panel.sv
`timescale 1ns/100ps
`default_nettype none
module tcd_switch_panel #(
  parameter int PRESS = 4
) (
  // Clock
  input  wire logic        clock,
  // Operator actions
  input  wire logic [10:0] held,
  input  wire logic [10:0] press,
  input  wire logic [10:0] pol,
  // Terminal wires
  output wire logic [10:0] raw
);
  logic [10:0] btn = 11'h000;
  int          cnt = 0;

  // enable kept
  // Maintained switches stay as held, enable included
  always @(posedge clock) begin
    if (press != 11'h000) begin
      btn <= press;
      cnt <= PRESS;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else begin
      btn <= 11'h000;
    end
  end

  assign raw = (held | btn) ^ pol;
endmodule
`default_nettype wire

//--- tcd_decoder_props.sv
`timescale 1ns/100ps
`default_nettype none
module tcd_decoder_props (
  // Clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // Watched ports
  input wire logic [10:0] terminal_state,
  input wire logic [1:0]  terminal_command_mode_select,
  input wire logic        run_command,
  input wire logic        reverse_command,
  input wire logic [1:0]  ramp_pair_select,
  input wire logic [3:0]  preset_index,
  input wire logic [31:0] updown_frequency,
  input wire logic signed [10:0] analog_setting
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // ------------------------------------------------------------
  // Three-wire start steps
  // ------------------------------------------------------------
  sequence fwd_press_s;
    terminal_command_mode_select == 2'h2 && terminal_state[2]
      && $rose(terminal_state[0]);
  endsequence
  sequence still_armed_s;
    terminal_command_mode_select == 2'h2 && terminal_state[2];
  endsequence

  preset_pick_a: assert property (
    1'b1 |=> preset_index == $past(terminal_state[6:3]))
    else $error("preset index does not follow switches");
  ramp_pick_a: assert property (
    1'b1 |=> ramp_pair_select == $past(terminal_state[8:7]))
    else $error("ramp pair does not follow terminals");
  two_wire_one_a: assert property (
    $past(terminal_command_mode_select) == 2'h0 |->
      run_command == ($past(terminal_state[0]) ^ $past(terminal_state[1]))
      && (!run_command || reverse_command == $past(terminal_state[1])))
    else $error("two-wire mode 1 command wrong");
  two_wire_two_a: assert property (
    $past(terminal_command_mode_select) == 2'h1 |->
      run_command == $past(terminal_state[0])
      && (!run_command || reverse_command == $past(terminal_state[1])))
    else $error("two-wire mode 2 command wrong");
  three_wire_stop_a: assert property (
    $past(terminal_command_mode_select[1]) && !$past(terminal_state[2])
      |-> !run_command)
    else $error("run kept without enable");
  three_wire_start_a: assert property (
    fwd_press_s ##1 still_armed_s |=> run_command && !reverse_command)
    else $error("forward press did not start");
  maintained_dir_a: assert property (
    $past(terminal_command_mode_select) == 2'h3 && run_command
      && $past(terminal_state[1]) == $past(terminal_state[1], 2)
      |-> reverse_command == $past(terminal_state[1]))
    else $error("direction input not followed");
  updown_hold_a: assert property (
    $past(terminal_state[10:9]) == 2'h3
      && $past(terminal_state[10:9], 2) == 2'h3 |-> $stable(updown_frequency))
    else $error("frequency moved with up and down both on");
  analog_range_a: assert property (
    analog_setting <= $signed(11'h3E8) && analog_setting >= -$signed(11'h3E8))
    else $error("analog setting out of range");
endmodule
`default_nettype wire

//--- test_terminal_command_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module test_terminal_command_decoder;
  logic         clock = 1'b0;
  logic         nrst = 1'b0;
  logic [10:0]  held = 11'h000;
  logic [10:0]  press = 11'h000;
  logic [10:0]  pol = 11'h000;
  logic [10:0]  raw;
  logic [9:0]   deb = 10'h000;
  logic [1:0]   mode = 2'h0;
  logic [255:0] presets = 256'h0;
  logic [15:0]  maxf = 16'h1388;
  logic [1:0]   dest = 2'h0;
  logic [15:0]  rate = 16'h03E8;
  logic [1:0]   res = 2'h2;
  logic [11:0]  ain = 12'h000;
  logic         cur = 1'b0;
  logic         bmh = 1'b0;
  logic [9:0]   aflt = 10'h000;
  logic         run, reverse_run_input;
  logic [1:0]   ramp;
  logic [3:0]   pidx;
  logic [16:0]  spd;
  logic [15:0]  pid, vf;
  logic [31:0]  udf, u0;
  logic [10:0]  aset, tstate;
  int           errors = 0;
  int           comparisons = 0;

  always #2.5 clock = ~clock;

  tcd_switch_panel u_panel (.clock(clock), .held(held), .press(press),
    .pol(pol), .raw(raw));

  tcd_terminal_command_decoder #(
    .TICK_CYCLES(20)
  ) u_tcd_terminal_command_decoder (
    .clock(clock), .nrst(nrst), .terminal_raw(raw),
    .input_polarity_select(pol), .input_debounce_time(deb),
    .terminal_command_mode_select(mode), .preset_reference_table(presets),
    .maximum_frequency_setting(maxf), .reference_destination(dest),
    .updown_ramp_rate(rate), .frequency_resolution_select(res),
    .analog_input_one(ain), .analog_current_mode(cur),
    .analog_min_input_point(10'h0C8), .analog_max_input_point(10'h320),
    .analog_min_setting(11'h60C), .analog_max_setting(11'h1F4),
    .analog_filter_time(aflt), .below_minimum_handling(bmh),
    .run_command(run), .reverse_command(reverse_run_input), .ramp_pair_select(ramp),
    .preset_index(pidx), .speed_reference(spd), .pid_setpoint(pid),
    .vf_voltage_setting(vf), .updown_frequency(udf),
    .analog_setting(aset), .terminal_state(tstate));

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic set_held(input logic [10:0] v, input int n);
    held <= v;
    wt(n);
  endtask
  task automatic press_btn(input logic [10:0] m);
    press <= m;
    wt(1);
    press <= 11'h000;
    wt(10);
  endtask
  task automatic ana(input logic [11:0] v, input logic c, input logic h,
                     input logic [10:0] e);
    ain <= v;
    cur <= c;
    bmh <= h;
    wt(6);
    chk(aset, e);
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    stop_test();
  end

  initial begin
    wt(8);
    nrst <= 1'b1;
    wt(2);
    chk(run, 0);
    // ------------------------------------------------------------
    // Two-wire modes over every switch combination
    // ------------------------------------------------------------
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 4; i++) begin
        mode <= 2'(m);
        set_held(11'(i), 4);
        chk(run, m ? i[0] : i[0] ^ i[1]);
        if (run === 1'b1) chk(reverse_run_input, i[1]);
      end
    end
    // ------------------------------------------------------------
    // Three-wire modes, enable kept by the operator
    // ------------------------------------------------------------
    mode <= 2'h2;
    set_held(11'h004, 4);
    press_btn(11'h001);
    chk({run, reverse_run_input}, 2'h2);
    press_btn(11'h002);
    chk({run, reverse_run_input}, 2'h3);
    set_held(11'h000, 4);
    chk(run, 0);
    press_btn(11'h001);
    chk(run, 0);
    mode <= 2'h3;
    set_held(11'h006, 4);
    press_btn(11'h001);
    chk({run, reverse_run_input}, 2'h3);
    set_held(11'h004, 4);
    chk({run, reverse_run_input}, 2'h2);
    set_held(11'h000, 4);
    chk(run, 0);
    // ------------------------------------------------------------
    // Presets and ramp pairs, all terminals inverted
    // ------------------------------------------------------------
    mode <= 2'h0;
    pol <= 11'h7FF;
    for (int i = 0; i < 16; i++) presets[16*i +: 16] <= 16'(i * 60);
    for (int i = 0; i < 16; i++) begin
      set_held(11'((i << 3) | ((i & 3) << 7)), 6);
      chk(pidx, i);
      chk(ramp, i & 3);
      chk(spd, i * 60 * maxf / 1000);
    end
    dest <= 2'h1;
    wt(4);
    chk(pid, 15 * 60);
    dest <= 2'h2;
    wt(4);
    chk(vf, 15 * 60);
    pol <= 11'h000;
    // ------------------------------------------------------------
    // Up/down ramp: both resolutions, hold, clamps
    // ------------------------------------------------------------
    set_held(11'h200, 50);
    u0 = udf;
    wt(100);
    chk(udf - u0, 5 * rate);
    res <= 2'h1;
    wt(20);
    u0 = udf;
    wt(100);
    chk(udf - u0, 50 * rate);
    set_held(11'h600, 20);
    u0 = udf;
    wt(100);
    chk(udf - u0, 0);
    rate <= 16'hFFFF;
    set_held(11'h200, 2000);
    chk(udf, maxf * 10000);
    set_held(11'h400, 2000);
    chk(udf, 0);
    set_held(11'h000, 2);
    // ------------------------------------------------------------
    // Analog curve from 2 V/-50% to 8 V/+50%
    // ------------------------------------------------------------
    ana(12'h1F4, 1'b0, 1'b0, 11'h000);
    ana(12'h28A, 1'b0, 1'b0, 11'h0FA);
    ana(12'h384, 1'b0, 1'b0, 11'h1F4);
    ana(12'h064, 1'b0, 1'b0, 11'h60C);
    ana(12'h064, 1'b0, 1'b1, 11'h000);
    ana(12'h514, 1'b1, 1'b0, 11'h0FA);
    // Filter of 0.01 s: two ticks are far from the step, many settle
    aflt <= 10'h001;
    ain  <= 12'h3E8;
    cur  <= 1'b0;
    wt(40);
    chk(aset == 11'h1F4, 0);
    wt(400);
    chk(aset, 11'h1F4);
    aflt <= 10'h000;
    // ------------------------------------------------------------
    // Debounce of 2 ms: short glitch dropped, long level taken
    // ------------------------------------------------------------
    deb <= 10'h002;
    wt(2);
    set_held(11'h080, 10);
    set_held(11'h000, 60);
    chk(tstate[7], 0);
    set_held(11'h080, 10);
    chk(tstate[7], 0);
    wt(60);
    chk(tstate[7], 1);
    chk(ramp, 1);
    stop_test();
  end
endmodule

bind tcd_terminal_command_decoder tcd_decoder_props u_tcd_decoder_props (
  .clock(clock), .nrst(nrst), .terminal_state(terminal_state),
  .terminal_command_mode_select(terminal_command_mode_select),
  .run_command(run_command), .reverse_command(reverse_command),
  .ramp_pair_select(ramp_pair_select), .preset_index(preset_index),
  .updown_frequency(updown_frequency), .analog_setting(analog_setting));
`default_nettype wire
